// >>> verilog/isrp_pkg.sv
// shared constants and types for the two-wire register port
package isrp_pkg;
  // ==========================================================
  // slave address choices, by the two address-select pins
  localparam logic [7:0] ADDR_SEL0   = 8'ha0;
  localparam logic [7:0] ADDR_SEL1   = 8'hb0;
  localparam logic [7:0] ADDR_SEL2   = 8'hc0;
  localparam logic [7:0] ADDR_SEL3   = 8'hd0;
  // ==========================================================
  // device register map, by pointer value
  localparam logic [7:0] TOC_PTR     = 8'h20;
  localparam logic [7:0] TOC_RESET   = 8'h00;
  localparam logic [7:0] REG_RESET   = 8'h00;
  localparam int         REG_DEPTH   = 16;
  localparam int         TO_EN_BIT   = 7;
  localparam int         TO_FLAG_BIT = 6;
  localparam int         TO_DUR_MSB  = 5;
  // ==========================================================
  // timeout clocking: subclock is clk/128, unit is 32 subclocks
  localparam int         SUB_DIV     = 128;
  localparam int         TO_UNIT_SUB = 32;
  // ==========================================================
  // host bit timing: clock rate and bus rate give a quarter bit
  localparam int         CLK_KHZ     = 100000;
  localparam int         BUS_KHZ     = 100;
  localparam int         QTR_CYC     = CLK_KHZ / (BUS_KHZ * 4);
  // ==========================================================
  // host command registers
  localparam logic [2:0] H_CTRL      = 3'h0;
  localparam logic [2:0] H_SLAVE     = 3'h1;
  localparam logic [2:0] H_REGA      = 3'h2;
  localparam logic [2:0] H_DATA      = 3'h3;
  localparam logic [2:0] H_STAT      = 3'h4;
  localparam int         CTRL_GO     = 0;
  localparam int         CTRL_RD     = 1;
  localparam int         STAT_BUSY   = 0;
  localparam int         STAT_NACK   = 1;
  // ==========================================================
  // state machines
  typedef enum logic [4:0] {
    D_IDLE = 5'h01, D_RECV = 5'h02, D_ACK = 5'h04, D_SEND = 5'h08, D_MACK = 5'h10
  } isrp_dstate_t;
  typedef enum logic [4:0] {
    H_IDLE = 5'h01, H_START = 5'h02, H_TX = 5'h04, H_RX = 5'h08, H_STOP = 5'h10
  } isrp_hstate_t;
endpackage : isrp_pkg

// >>> verilog/isrp_if.sv
// open-drain two-wire bus joining host and device
`timescale 1ns/10ps
interface isrp_if;
  logic hostSclO;
  logic hostSclOeN;
  logic hostSdaO;
  logic hostSdaOeN;
  logic devSdaO;
  logic devSdaOeN;
  logic scl;
  logic sda;
  // ==========================================================
  // wired-and lines, pulled high when nobody drives low
  assign scl = hostSclOeN | hostSclO;
  assign sda = (hostSdaOeN | hostSdaO) & (devSdaOeN | devSdaO);
  modport dev  (input scl, input sda, output devSdaO, output devSdaOeN);
  modport host (input scl, input sda, output hostSclO, output hostSclOeN,
                output hostSdaO, output hostSdaOeN);
endinterface : isrp_if

// >>> verilog/isrp_device.sv
// two-wire slave register port of the converter device
`timescale 1ns/10ps
module isrp_device
  import isrp_pkg::*;
#(
  parameter int SUB_DIV = isrp_pkg::SUB_DIV
) (
  input  wire logic       clk,
  input  wire logic       rst,
  isrp_if.dev             bus,
  input  wire logic       ifSelPin,
  input  wire logic       addrSelLoPin,
  input  wire logic       addrSelHiPin,
  output logic            busy,
  output logic            timeoutFlag,
  output logic            timeoutEnable,
  output logic            wrStb,
  output logic [7:0]      wrAddr,
  output logic [7:0]      wrData
);
  localparam int UNIT_CYC = SUB_DIV * TO_UNIT_SUB;
  localparam int PW       = $clog2(UNIT_CYC);
  localparam logic [PW-1:0] UNIT_LAST = PW'(UNIT_CYC - 1);

  logic [2:0]   sclSh_r;
  logic [2:0]   sdaSh_r;
  logic [1:0]   selSh_r;
  logic [1:0]   loSh_r;
  logic [1:0]   hiSh_r;
  logic         sclS;
  logic         sclP;
  logic         sdaS;
  logic         sdaP;
  logic         enabled;
  logic         startEv;
  logic         stopEv;
  logic         sclRise;
  logic         sclFall;
  logic [6:0]   myAddr;
  isrp_dstate_t state_r;
  logic [3:0]   bitCnt_r;
  logic [1:0]   byteIdx_r;
  logic [7:0]   rxShift_r;
  logic [7:0]   txShift_r;
  logic         readDir_r;
  logic         mackOk_r;
  logic [7:0]   ptr_r;
  logic [7:0]   toc_r;
  logic [7:0]   mem_r [REG_DEPTH];
  logic [7:0]   rdVal;
  logic         byteIn;
  logic         tocWr;
  logic [PW-1:0] preCnt_r;
  logic [5:0]   unitCnt_r;
  logic         unitTick;
  logic         expire;

  // ==========================================================
  // pin synchronisers; only stage 1 onward feeds any logic
  always_ff @(posedge clk) begin
    if (rst) begin
      sclSh_r <= 3'h7;
      sdaSh_r <= 3'h7;
      selSh_r <= 2'h0;
      loSh_r  <= 2'h0;
      hiSh_r  <= 2'h0;
    end else begin
      sclSh_r <= {sclSh_r[1:0], bus.scl};
      sdaSh_r <= {sdaSh_r[1:0], bus.sda};
      selSh_r <= {selSh_r[0], ifSelPin};
      loSh_r  <= {loSh_r[0], addrSelLoPin};
      hiSh_r  <= {hiSh_r[0], addrSelHiPin};
    end
  end

  // ==========================================================
  // line events
  assign sclS    = sclSh_r[1];
  assign sclP    = sclSh_r[2];
  assign sdaS    = sdaSh_r[1];
  assign sdaP    = sdaSh_r[2];
  assign enabled = !selSh_r[1];
  assign startEv = enabled && sclS && sclP && sdaP && !sdaS;
  assign stopEv  = sclS && sclP && !sdaP && sdaS;
  assign sclRise = sclS && !sclP;
  assign sclFall = !sclS && sclP;

  // address pins only count while the two-wire bus is selected
  always_comb begin
    case ({hiSh_r[1], loSh_r[1]})
      2'b00:   myAddr = ADDR_SEL0[7:1];
      2'b01:   myAddr = ADDR_SEL1[7:1];
      2'b10:   myAddr = ADDR_SEL2[7:1];
      default: myAddr = ADDR_SEL3[7:1];
    endcase
  end

  // ==========================================================
  // register read mux and write decode
  always_comb begin
    if (ptr_r == TOC_PTR) begin
      rdVal = toc_r;
    end else if (ptr_r < 8'(REG_DEPTH)) begin
      rdVal = mem_r[ptr_r[3:0]];
    end else begin
      rdVal = 8'h00;
    end
  end
  // a full byte is in after the eighth rise, acted on at the fall
  assign byteIn = (state_r == D_RECV) && sclFall && (bitCnt_r == 4'h8);
  assign tocWr  = byteIn && (byteIdx_r == 2'h2) && (ptr_r == TOC_PTR);

  // ==========================================================
  // byte framing state machine; sda only moves after scl falls, except the release on deselect, start, stop or expiry
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r   <= D_IDLE;
      bitCnt_r  <= 4'h0;
      byteIdx_r <= 2'h0;
      rxShift_r <= 8'h00;
      txShift_r <= 8'h00;
      readDir_r <= 1'b0;
      mackOk_r  <= 1'b0;
      bus.devSdaOeN <= 1'b1;
    end else if (!enabled || stopEv || expire) begin
      state_r   <= D_IDLE;
      bus.devSdaOeN <= 1'b1;
    end else if (startEv) begin
      state_r   <= D_RECV;
      bitCnt_r  <= 4'h0;
      byteIdx_r <= 2'h0;
      bus.devSdaOeN <= 1'b1;
    end else begin
      case (state_r)
        D_RECV: begin
          if (sclRise && bitCnt_r != 4'h8) begin
            rxShift_r <= {rxShift_r[6:0], sdaS};
            bitCnt_r  <= bitCnt_r + 4'h1;
          end else if (byteIn) begin
            bitCnt_r <= 4'h0;
            if (byteIdx_r != 2'h0 || rxShift_r[7:1] == myAddr) begin
              state_r       <= D_ACK;
              bus.devSdaOeN <= 1'b0;
              if (byteIdx_r == 2'h0) begin
                readDir_r <= rxShift_r[0];
              end
            end else begin
              state_r <= D_IDLE;
            end
          end
        end
        D_ACK: begin
          // ack held low over the whole ninth clock high phase
          if (sclFall) begin
            if (readDir_r && byteIdx_r == 2'h0) begin
              state_r       <= D_SEND;
              txShift_r     <= {rdVal[6:0], 1'b0};
              bus.devSdaOeN <= rdVal[7];
              bitCnt_r      <= 4'h1;
            end else begin
              state_r       <= D_RECV;
              bus.devSdaOeN <= 1'b1;
              if (byteIdx_r != 2'h2) begin
                byteIdx_r <= byteIdx_r + 2'h1;
              end
            end
          end
        end
        D_SEND: begin
          if (sclFall) begin
            if (bitCnt_r == 4'h8) begin
              state_r       <= D_MACK;
              bus.devSdaOeN <= 1'b1;
            end else begin
              bus.devSdaOeN <= txShift_r[7];
              txShift_r     <= {txShift_r[6:0], 1'b0};
              bitCnt_r      <= bitCnt_r + 4'h1;
            end
          end
        end
        D_MACK: begin
          // master ack repeats the same register; nack ends the read
          if (sclRise) begin
            mackOk_r <= !sdaS;
          end else if (sclFall) begin
            if (mackOk_r) begin
              state_r       <= D_SEND;
              txShift_r     <= {rdVal[6:0], 1'b0};
              bus.devSdaOeN <= rdVal[7];
              bitCnt_r      <= 4'h1;
            end else begin
              state_r <= D_IDLE;
            end
          end
        end
        default: state_r <= D_IDLE;
      endcase
    end
  end

  // open-drain: the data value is always low, only the enable moves
  always_ff @(posedge clk) begin
    bus.devSdaO <= 1'b0;
  end

  // ==========================================================
  // pointer and register file writes
  always_ff @(posedge clk) begin
    if (rst) begin
      ptr_r  <= 8'h00;
      wrStb  <= 1'b0;
      wrAddr <= 8'h00;
      wrData <= 8'h00;
      for (int i = 0; i < REG_DEPTH; i++) begin
        mem_r[i] <= REG_RESET;
      end
    end else begin
      wrStb <= 1'b0;
      if (byteIn && byteIdx_r == 2'h1) begin
        ptr_r <= rxShift_r;
      end
      if (byteIn && byteIdx_r == 2'h2) begin
        wrStb  <= 1'b1;
        wrAddr <= ptr_r;
        wrData <= rxShift_r;
        if (ptr_r < 8'(REG_DEPTH)) begin
          mem_r[ptr_r[3:0]] <= rxShift_r;
        end
      end
    end
  end

  // ==========================================================
  // timeout control; a flag write of 0 clears, but expiry wins
  always_ff @(posedge clk) begin
    if (rst) begin
      toc_r <= TOC_RESET;
    end else begin
      if (tocWr) begin
        toc_r[TO_EN_BIT]      <= rxShift_r[TO_EN_BIT];
        toc_r[TO_DUR_MSB:0]   <= rxShift_r[TO_DUR_MSB:0];
      end
      toc_r[TO_FLAG_BIT] <= expire ||
        (toc_r[TO_FLAG_BIT] && !(tocWr && !rxShift_r[TO_FLAG_BIT]));
    end
  end

  // unit tick is 32 subclocks of clk/SUB_DIV, restarted by scl edges
  assign unitTick = (preCnt_r == UNIT_LAST);
  assign expire   = toc_r[TO_EN_BIT] && state_r != D_IDLE && unitTick &&
                    (unitCnt_r == toc_r[TO_DUR_MSB:0]);
  always_ff @(posedge clk) begin
    if (rst || state_r == D_IDLE || sclRise || sclFall) begin
      preCnt_r  <= '0;
      unitCnt_r <= 6'h00;
    end else begin
      preCnt_r <= unitTick ? '0 : preCnt_r + PW'(1);
      if (unitTick) begin
        unitCnt_r <= unitCnt_r + 6'h01;
      end
    end
  end

  // ==========================================================
  // status outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      busy          <= 1'b0;
      timeoutFlag   <= 1'b0;
      timeoutEnable <= 1'b0;
    end else begin
      busy          <= (state_r != D_IDLE);
      timeoutFlag   <= toc_r[TO_FLAG_BIT];
      timeoutEnable <= toc_r[TO_EN_BIT];
    end
  end
endmodule : isrp_device

// >>> verilog/isrp_host.sv
// two-wire bus master that performs single-byte register accesses
`timescale 1ns/10ps
module isrp_host
  import isrp_pkg::*;
#(
  parameter int QTR = isrp_pkg::QTR_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst,
  isrp_if.host            bus,
  input  wire logic [2:0] addr,
  input  wire logic [7:0] wrData,
  input  wire logic       wrStb,
  input  wire logic       rdStb,
  output logic [7:0]      rdData
);
  localparam int QW = $clog2(QTR + 1);

  logic [1:0]   sdaSh_r;
  isrp_hstate_t state_r;
  logic [QW-1:0] div_r;
  logic         qTick;
  logic [1:0]   q_r;
  logic [3:0]   bitCnt_r;
  logic [2:0]   step_r;
  logic [7:0]   sh_r;
  logic [6:0]   slave_r;
  logic [7:0]   regA_r;
  logic [7:0]   txData_r;
  logic [7:0]   rxData_r;
  logic         isRead_r;
  logic         nack_r;
  logic         go;

  // ==========================================================
  // command registers, read data one cycle after the strobe
  assign go = wrStb && addr == H_CTRL && wrData[CTRL_GO] && state_r == H_IDLE;
  always_ff @(posedge clk) begin
    if (rst) begin
      slave_r  <= 7'h00;
      regA_r   <= 8'h00;
      txData_r <= 8'h00;
      isRead_r <= 1'b0;
      rdData   <= 8'h00;
    end else begin
      if (wrStb && addr == H_SLAVE) slave_r  <= wrData[6:0];
      if (wrStb && addr == H_REGA)  regA_r   <= wrData;
      if (wrStb && addr == H_DATA)  txData_r <= wrData;
      if (go)                       isRead_r <= wrData[CTRL_RD];
      case (addr)
        H_SLAVE: rdData <= {1'b0, slave_r};
        H_REGA:  rdData <= regA_r;
        H_DATA:  rdData <= rxData_r;
        H_STAT:  rdData <= {6'h00, nack_r, state_r != H_IDLE};
        default: rdData <= 8'h00;
      endcase
      if (!rdStb) rdData <= 8'h00;
    end
  end

  // ==========================================================
  // pin synchronisers and quarter-bit divider
  always_ff @(posedge clk) begin
    if (rst) begin
      sdaSh_r <= 2'h3;
      div_r   <= '0;
    end else begin
      sdaSh_r <= {sdaSh_r[0], bus.sda};
      div_r   <= (qTick || state_r == H_IDLE) ? '0 : div_r + QW'(1);
    end
  end
  assign qTick = (div_r == QW'(QTR - 1));

  // ==========================================================
  // bit engine; data bits move sda in quarter 0 with scl low, start and stop move it in quarter 2 with scl high
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= H_IDLE;
      q_r <= 2'h0;
      bitCnt_r <= 4'h0;
      step_r <= 3'h0;
      sh_r <= 8'h00;
      rxData_r <= 8'h00;
      nack_r <= 1'b0;
      bus.hostSclOeN <= 1'b1;
      bus.hostSdaOeN <= 1'b1;
      bus.hostSclO <= 1'b0;
      bus.hostSdaO <= 1'b0;
    end else if (go) begin
      // idle bus is free: both lines released
      state_r <= H_START;
      q_r <= 2'h0;
      step_r <= 3'h0;
      nack_r <= 1'b0;
    end else if (qTick) begin
      q_r <= q_r + 2'h1;
      case (state_r)
        H_START: begin
          case (q_r)
            2'h0: bus.hostSdaOeN <= 1'b1;
            2'h1: bus.hostSclOeN <= 1'b1;
            2'h2: bus.hostSdaOeN <= 1'b0;
            default: begin
              bus.hostSclOeN <= 1'b0;
              state_r  <= H_TX;
              bitCnt_r <= 4'h0;
              sh_r     <= {slave_r, step_r != 3'h0};
            end
          endcase
        end
        H_TX, H_RX: begin
          case (q_r)
            2'h0: bus.hostSdaOeN <= (state_r == H_RX) || bitCnt_r == 4'h8 || sh_r[7];
            2'h1: bus.hostSclOeN <= 1'b1;
            2'h2: begin
              if (bitCnt_r == 4'h8 && state_r == H_TX) nack_r <= sdaSh_r[1];
              if (bitCnt_r != 4'h8 && state_r == H_RX) rxData_r <= {rxData_r[6:0], sdaSh_r[1]};
            end
            default: begin
              bus.hostSclOeN <= 1'b0;
              sh_r     <= {sh_r[6:0], 1'b0};
              bitCnt_r <= bitCnt_r + 4'h1;
              if (bitCnt_r == 4'h8) begin
                bitCnt_r <= 4'h0;
                step_r   <= step_r + 3'h1;
                // write: addr, reg, data; read: addr, reg, restart, addr, data
                if (state_r == H_RX || nack_r || (step_r == 3'h2 && !isRead_r)) begin
                  state_r <= H_STOP;
                end else if (step_r == 3'h1 && isRead_r) begin
                  state_r <= H_START;
                end else if (step_r == 3'h2) begin
                  state_r <= H_RX;
                end else begin
                  sh_r <= (step_r == 3'h0) ? regA_r : txData_r;
                end
              end
            end
          endcase
        end
        H_STOP: begin
          case (q_r)
            2'h0: bus.hostSdaOeN <= 1'b0;
            2'h1: bus.hostSclOeN <= 1'b1;
            2'h2: bus.hostSdaOeN <= 1'b1;
            default: state_r <= H_IDLE;
          endcase
        end
        default: state_r <= H_IDLE;
      endcase
    end
  end
endmodule : isrp_host

// >>> test/isrp_properties.sv
// concurrent checks on the two-wire bus between host and device
`timescale 1ns/10ps
module isrp_properties (
  input wire logic clk,
  input wire logic rst,
  input wire logic hostSclO,
  input wire logic hostSclOeN,
  input wire logic hostSdaO,
  input wire logic hostSdaOeN,
  input wire logic devSdaO,
  input wire logic devSdaOeN,
  input wire logic scl,
  input wire logic sda,
  input wire logic ifSelPin,
  input wire logic busy,
  input wire logic wrStb
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // ==========================================================
  // bus events, seen on the wired lines
  sequence startSeen;
    scl && $fell(sda);
  endsequence
  sequence stopSeen;
    scl && $rose(sda);
  endsequence
  sequence sclHeld;
    scl ##1 scl;
  endsequence
  // ==========================================================
  // line discipline: nobody may drive a line high
  a_dev_open_drain: assert property (!devSdaO)
    else $error("device drives sda high");
  a_host_open_drain: assert property (!hostSdaO && !hostSclO)
    else $error("host drives a line high");
  // device data may only move while the clock is low
  a_dev_data_stable: assert property (sclHeld |-> $stable(devSdaOeN))
    else $error("device sda moved with scl high");
  // a start needs a free bus, so the device must not be pulling sda
  a_start_bus_free: assert property (startSeen |-> $past(scl) && $past(devSdaOeN))
    else $error("start while bus not free");
  // a stop sends the device back to idle within a few cycles
  a_stop_idles: assert property (stopSeen |-> ##[1:8] !busy)
    else $error("device still busy after stop");
  // a low driven by the device lasts at least nine cycles, not a glitch
  a_ack_held: assert property ($fell(devSdaOeN) |-> !scl ##1 (!devSdaOeN)[*8])
    else $error("device low too short or started with scl high");
  // ==========================================================
  // select pin, idle release and write strobe
  a_sel_high_quiet: assert property (ifSelPin[*6] |-> devSdaOeN && !busy)
    else $error("device active while deselected");
  a_idle_release: assert property (!busy && !$past(busy) |-> devSdaOeN)
    else $error("idle device drives sda");
  a_wr_pulse_one: assert property (wrStb |=> !wrStb)
    else $error("write strobe longer than one cycle");
  a_wr_in_frame: assert property (wrStb |-> busy && !scl)
    else $error("write strobe outside a transfer");
endmodule : isrp_properties

// >>> test/i2c_slave_register_port_tb.sv
// bench: host and device pair, plus a second device driven by a bit-banged master
`timescale 1ns/10ps
module i2c_slave_register_port_tb;
  import isrp_pkg::*;
  localparam int UNIT = TO_UNIT_SUB * 2;
  logic        clk, rst, hWr, hRd, ifSel, busy, toFlag, toEn, wStb, busy2, toFlag2, rdPend;
  logic [2:0]  hAddr;
  logic [1:0]  aSel, dur;
  logic [7:0]  hWd, hRdData, wAddr, wData, ra, st;
  logic [15:0] nRd, nWr;
  logic [31:0] rnd;
  logic [15:0] expRd[$];
  logic [15:0] expWr[$];
  logic [7:0]  adTab[4];
  int          fails, n_compared, n;
  isrp_if bus();
  isrp_if bus2();
  isrp_host #(.QTR(8)) isrp_host_inst (.clk(clk), .rst(rst), .bus(bus.host), .addr(hAddr),
    .wrData(hWd), .wrStb(hWr), .rdStb(hRd), .rdData(hRdData));
  isrp_device #(.SUB_DIV(2)) isrp_device_inst (.clk(clk), .rst(rst), .bus(bus.dev),
    .ifSelPin(ifSel), .addrSelLoPin(aSel[0]), .addrSelHiPin(aSel[1]), .busy(busy),
    .timeoutFlag(toFlag), .timeoutEnable(toEn), .wrStb(wStb), .wrAddr(wAddr), .wrData(wData));
  isrp_device #(.SUB_DIV(2)) isrp_device_inst2 (.clk(clk), .rst(rst), .bus(bus2.dev),
    .ifSelPin(1'b0), .addrSelLoPin(aSel[0]), .addrSelHiPin(aSel[1]), .busy(busy2),
    .timeoutFlag(toFlag2), .timeoutEnable(), .wrStb(), .wrAddr(), .wrData());
  isrp_properties isrp_properties_inst (.clk(clk), .rst(rst), .hostSclO(bus.hostSclO),
    .hostSclOeN(bus.hostSclOeN), .hostSdaO(bus.hostSdaO), .hostSdaOeN(bus.hostSdaOeN),
    .devSdaO(bus.devSdaO), .devSdaOeN(bus.devSdaOeN), .scl(bus.scl), .sda(bus.sda),
    .ifSelPin(ifSel), .busy(busy), .wrStb(wStb));
  // ==========================================================
  // clock and shared helpers
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk
  task automatic done_test(input string s);
    $display("test %s done, mismatches %0d", s, fails);
  endtask : done_test
  task automatic print_verdict;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict
  // ==========================================================
  // host port accesses; a gap cycle keeps each strobe one edge wide
  task automatic hwr(input logic [2:0] a, input logic [7:0] d);
    hAddr <= a;
    hWd   <= d;
    hWr   <= 1'b1;
    @(posedge clk);
    hWr   <= 1'b0;
    @(posedge clk);
  endtask : hwr
  task automatic hrd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m,
                     output logic [7:0] v);
    expRd.push_back({e, m});
    hAddr <= a;
    hRd   <= 1'b1;
    @(posedge clk);
    hRd   <= 1'b0;
    #1;
    v = hRdData;
    @(posedge clk);
  endtask : hrd
  task automatic xfer(input logic [6:0] sl, input logic [7:0] r, input logic [7:0] d,
                      input logic rd);
    hwr(H_SLAVE, {1'b0, sl});
    hwr(H_REGA, r);
    hwr(H_DATA, d);
    hwr(H_CTRL, {6'h00, rd, 1'b1});
    st = 8'h01;
    for (n = 0; n < 4000 && st[STAT_BUSY] !== 1'b0; n++) hrd(H_STAT, 8'h00, 8'h00, st);
    if (n >= 4000) begin
      chk(8'h01, 8'h00, "host stays busy");
      print_verdict();
    end
  endtask : xfer
  // ==========================================================
  // bit-banged master on the second bus, one quarter is 8 cycles
  task automatic bb(input logic c, input logic d);
    bus2.hostSclOeN <= c;
    bus2.hostSdaOeN <= d;
    repeat (8) @(posedge clk);
  endtask : bb
  task automatic bb_bit(input logic d);
    bb(1'b0, d);
    bb(1'b1, d);
    bb(1'b0, d);
  endtask : bb_bit
  task automatic bb_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) bb_bit(b[i]);
  endtask : bb_byte
  task automatic bb_write(input logic [7:0] d);
    bb(1'b1, 1'b0);
    bb_byte({adTab[aSel][7:1], 1'b0});
    bb_bit(1'b1);
    bb_byte(TOC_PTR);
    bb_bit(1'b1);
    bb_byte(d);
    bb_bit(1'b1);
    bb(1'b0, 1'b0);
    bb(1'b1, 1'b0);
    bb(1'b1, 1'b1);
  endtask : bb_write
  // ==========================================================
  // results are matched against the oldest note of the driver
  always @(posedge clk) begin
    rdPend <= hRd;
    if (rdPend === 1'b1) begin
      nRd = expRd.pop_front();
      chk(hRdData & nRd[7:0], nRd[15:8] & nRd[7:0], "read data");
    end
    if (wStb === 1'b1) begin
      nWr = (expWr.size() > 0) ? expWr.pop_front() : 16'hxxxx;
      chk(wAddr, nWr[15:8], "write pointer");
      chk(wData, nWr[7:0], "write data");
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    rnd = 32'h9e750d7e;
    {rst, hWr, hRd, ifSel, aSel, hAddr, hWd} = {1'b1, 16'h0000};
    {fails, n_compared} = '0;
    {bus2.hostSclO, bus2.hostSdaO, bus2.hostSclOeN, bus2.hostSdaOeN} = 4'h3;
    adTab = '{ADDR_SEL0, ADDR_SEL1, ADDR_SEL2, ADDR_SEL3};
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk({6'h00, toEn, toFlag}, 8'h00, "timeout bits at reset");
    xfer(adTab[0][7:1], TOC_PTR, 8'h00, 1'b1);
    hrd(H_DATA, TOC_RESET, 8'hff, st);
    hrd(H_SLAVE, {1'b0, ADDR_SEL0[7:1]}, 8'hff, st);
    hrd(H_REGA, TOC_PTR, 8'hff, st);
    hrd(3'h6, 8'h00, 8'hff, st);
    done_test("reset values");
    for (int i = 0; i < 4; i++) begin
      aSel <= i[1:0];
      rnd = lfsr(rnd);
      ra = {4'h0, rnd[3:0]};
      expWr.push_back({ra, rnd[15:8]});
      xfer(adTab[i][7:1], ra, rnd[15:8], 1'b0);
      hrd(H_STAT, 8'h00, 8'h02, st);
      xfer(adTab[i][7:1], ra, 8'h00, 1'b1);
      hrd(H_DATA, rnd[15:8], 8'hff, st);
      xfer(adTab[(i + 1) % 4][7:1], ra, 8'h5a, 1'b0);
      hrd(H_STAT, 8'h02, 8'h02, st);
    end
    done_test("address select");
    ifSel <= 1'b1;
    repeat (4) @(posedge clk);
    xfer(adTab[3][7:1], 8'h01, 8'h33, 1'b0);
    hrd(H_STAT, 8'h02, 8'h02, st);
    ifSel <= 1'b0;
    expWr.push_back({TOC_PTR, 8'hbf});
    xfer(adTab[3][7:1], TOC_PTR, 8'hbf, 1'b0);
    xfer(adTab[3][7:1], TOC_PTR, 8'h00, 1'b1);
    hrd(H_DATA, 8'hbf, 8'hff, st);
    chk({6'h00, toEn, toFlag}, 8'h02, "enable set, no timeout");
    done_test("select pin and timeout register");
    rnd = lfsr(rnd);
    dur = rnd[1:0];
    bb_write({2'b10, 4'h0, dur});
    bb(1'b1, 1'b0);
    bb_byte({adTab[aSel][7:1], 1'b0});
    for (n = 8; n < 2000 && toFlag2 !== 1'b1; n++) @(posedge clk);
    if (n >= 2000) begin
      chk(8'h01, 8'h00, "no timeout flag");
      print_verdict();
    end
    chk({7'h00, n >= (dur + 1) * UNIT && n <= (dur + 1) * UNIT + 8}, 8'h01, "expiry time");
    chk({6'h00, bus2.devSdaOeN, busy2}, 8'h02, "release on expiry");
    repeat (300) @(posedge clk);
    chk({7'h00, toFlag2}, 8'h01, "flag kept");
    bb(1'b0, 1'b0);
    bb(1'b1, 1'b0);
    bb(1'b1, 1'b1);
    bb_write(8'h80);
    chk({7'h00, toFlag2}, 8'h00, "flag cleared by write");
    done_test("bus timeout");
    chk(8'(expWr.size() + expRd.size()), 8'h00, "notes left over");
    print_verdict();
  end
endmodule : i2c_slave_register_port_tb
